/* pkg/lgf_pkg.sv */
// Purpose: Shared constants and carrier types for the link pin forwarding block.
// Assumes: One 100 MHz clock; registers reached through an 8-bit internal register port.
// Notes: Pin output control, port select, rate and level status offsets sit beside the table.
package lgf_pkg;

   localparam int NUM_PINS = 7;
   localparam int NUM_PORTS = 2;
   localparam int NUM_SLOTS = 4;
   localparam int FWD_PINS = 4;

   // Register offsets.
   localparam logic [7:0] ADDR_PIN_LEVEL = 8'h0E;
   localparam logic [7:0] ADDR_INPUT_EN = 8'h0F;
   localparam logic [7:0] ADDR_PIN_OUT_BASE = 8'h10;
   localparam logic [7:0] ADDR_PORT_SEL = 8'h20;
   localparam logic [7:0] ADDR_BC_RATE = 8'h21;
   localparam logic [7:0] ADDR_BC_SLOT0 = 8'h6E;
   localparam logic [7:0] ADDR_BC_SLOT1 = 8'h6F;
   localparam logic [7:0] ADDR_PULLDOWN = 8'hBE;

   // Reset values.
   localparam logic [7:0] INPUT_EN_RST = 8'h7F;
   localparam logic [7:0] PULLDOWN_RST = 8'h7F;
   localparam logic [7:0] PIN_OUT_RST = 8'h00;
   localparam logic [3:0] BC_SLOT_RST = 4'h0;
   localparam logic [1:0] BC_RATE_RST = 2'h0;

   // Field positions.
   localparam int PCFG_OE_BIT = 0;
   localparam int PCFG_VAL_BIT = 1;
   localparam int PCFG_SEL_LSB = 2;
   localparam int PCFG_GRP_LSB = 5;
   localparam int SLOT_LO_LSB = 0;
   localparam int SLOT_HI_LSB = 4;

   // Output source groups and select codes.
   localparam logic [2:0] GRP_PORT0 = 3'h0;
   localparam logic [2:0] GRP_PORT1 = 3'h1;
   localparam logic [2:0] GRP_STATUS = 3'h4;
   localparam logic [2:0] SEL_PORT_LOCK = 3'h4;
   localparam logic [2:0] SEL_STAT_VALUE = 3'h0;
   localparam logic [2:0] SEL_STAT_LOCK_OR = 3'h1;
   localparam logic [2:0] SEL_STAT_LOCK_AND = 3'h2;
   localparam logic [2:0] SEL_STAT_FSYNC = 3'h4;

   // Back-channel slot source codes; 0 to 6 pick a pin.
   localparam logic [3:0] SLOT_FSYNC_INT = 4'h7;
   localparam logic [3:0] SLOT_FSYNC_EXT = 4'h8;

   // Back-channel rate codes.
   localparam logic [1:0] BC_RATE_50M = 2'h0;
   localparam logic [1:0] BC_RATE_10M = 2'h1;
   localparam logic [1:0] BC_RATE_2M5 = 2'h2;

   // Timing.
   localparam int CLK_FREQ_MHZ = 100;
   localparam int BC_FRAME_BITS = 30;
   localparam int BC_BIT_NS_50M = 20;
   localparam int BC_BIT_NS_10M = 100;
   localparam int BC_BIT_NS_2M5 = 400;
   localparam int BC_FRAME_CYC_50M = BC_FRAME_BITS * BC_BIT_NS_50M * CLK_FREQ_MHZ / 1000;
   localparam int BC_FRAME_CYC_10M = BC_FRAME_BITS * BC_BIT_NS_10M * CLK_FREQ_MHZ / 1000;
   localparam int BC_FRAME_CYC_2M5 = BC_FRAME_BITS * BC_BIT_NS_2M5 * CLK_FREQ_MHZ / 1000;
   localparam logic [2:0] FC_PERIOD_ONE = 3'h1;
   localparam logic [2:0] FC_PERIOD_TWO = 3'h2;
   localparam logic [2:0] FC_PERIOD_MANY = 3'h5;

   typedef struct packed {
      logic stb;
      logic [2:0] link_cnt;
      logic [FWD_PINS-1:0] vals;
   } lgf_fwd_frame_t;

   typedef struct packed {
      logic [2:0] grp;
      logic [2:0] sel;
      logic val;
      logic oe;
   } lgf_pin_cfg_t;

endpackage

/* src/lgf_pin_sync.sv */
// Purpose: Three-stage synchronizer with agreement filter for asynchronous pin levels.
// Assumes: Inputs change slower than a few clock periods.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/10ps
`default_nettype none
module lgf_pin_sync #(
   parameter int W = 8
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] level
);
   import lgf_pkg::*;

   logic [W-1:0] s1_ff;
   logic [W-1:0] s2_ff;
   logic [W-1:0] s3_ff;
   logic [W-1:0] level_ff;

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         s1_ff <= '0;
         s2_ff <= '0;
         s3_ff <= '0;
      end
      else
      begin
         s1_ff <= async_in;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end

   // A change is accepted per bit only when two settled stages agree.
   for (genvar i = 0; i < W; i++)
   begin : g_bit
      always_ff @(posedge clk or negedge arst_n)
      begin
         if (!arst_n)
            level_ff[i] <= 1'b0;
         else if (s2_ff[i] == s3_ff[i])
            level_ff[i] <= s3_ff[i];
      end
   end

   assign level = level_ff;
endmodule
`default_nettype wire

/* src/lgf_bc_frame_timer.sv */
// Purpose: Marks the start of each back-channel frame of 30 bit periods.
// Assumes: Rate code is static while in use; a change restarts the frame.
// Notes: Unknown rate codes fall back to the fastest rate.
`timescale 1ns/10ps
`default_nettype none
module lgf_bc_frame_timer (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [1:0] rate,
   output logic frame_stb
);
   import lgf_pkg::*;

   localparam logic [10:0] LAST_50M = 11'(BC_FRAME_CYC_50M - 1);
   localparam logic [10:0] LAST_10M = 11'(BC_FRAME_CYC_10M - 1);
   localparam logic [10:0] LAST_2M5 = 11'(BC_FRAME_CYC_2M5 - 1);

   logic [10:0] cnt_ff;
   logic [1:0] rate_ff;
   logic stb_ff;
   logic [10:0] last;

   always_comb
   begin
      if (rate == BC_RATE_2M5)
         last = LAST_2M5;
      else if (rate == BC_RATE_10M)
         last = LAST_10M;
      else
         last = LAST_50M;
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cnt_ff <= '0;
         rate_ff <= BC_RATE_RST;
         stb_ff <= 1'b0;
      end
      else
      begin
         rate_ff <= rate;
         stb_ff <= (cnt_ff >= last) && (rate_ff == rate);
         if (cnt_ff >= last || rate_ff != rate)
            cnt_ff <= '0;
         else
            cnt_ff <= cnt_ff + 11'h001;
      end
   end

   assign frame_stb = stb_ff;
endmodule
`default_nettype wire

/* src/lgf_gpio_fwd.sv */
// Purpose: Forwards pin levels across the serial camera link in both directions.
// Assumes: Forward frames and lock come from same-clock link logic; pins are asynchronous.
// Notes: Registers are reached through the internal 8-bit register port; read data lags one cycle.
// Contract
// - Any of the seven pins can be driven by forward-channel values.
// - Each pin is programmed into output mode and given a forward source.
// - At most four forward-channel pin values are accepted per receive port.
// - Any forward value from either port can reach any output pin.
// - Updates every frame, every second frame, or every fifth frame by link count.
// - Forward latency stays near 130 ns whatever the link count.
// - Output jitter grows with the number of frames between updates.
// - Internal frame sync or control signals can drive any local pin.
// - Every pin comes up as an input after reset.
// - Each receive port has up to four back-channel slots of pin values.
// - Each slot of each port may carry any of the seven pin inputs.
// - One pin may feed several slots at once.
// - A back-channel frame lasts 30 bit periods.
// - Linked inputs are sampled and sent once every back-channel frame.
// - Internal or external frame sync may be chosen for any slot.
// - Slot assignment per port sits in the registers at 0x6E and 0x6F.
// - Per-pin input and pulldown controls, both enabled at reset.
// - Input enables live at 0x0F, pulldown enables at 0xBE.
// - Status group, select 000 drives the programmed output value bit.
// - Status group, select 001 drives the OR of enabled port locks.
`timescale 1ns/10ps
`default_nettype none
module lgf_gpio_fwd #(
   parameter int N_PINS = lgf_pkg::NUM_PINS,
   parameter int N_PORTS = lgf_pkg::NUM_PORTS,
   parameter int N_SLOTS = lgf_pkg::NUM_SLOTS
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire lgf_pkg::lgf_fwd_frame_t [N_PORTS-1:0] fwd_frame,
   input wire logic [N_PORTS-1:0] rx_port_en,
   input wire logic [N_PORTS-1:0] rx_lock,
   input wire logic frame_sync_int,
   input wire logic frame_sync_ext,
   input wire logic [N_PINS-1:0] pin_in,
   output logic [N_PINS-1:0] pin_out,
   output logic [N_PINS-1:0] pin_oe_n,
   output logic [N_PINS-1:0] pin_in_en,
   output logic [N_PINS-1:0] pin_pd_en,
   output logic bc_frame_stb,
   output logic [N_PORTS-1:0][N_SLOTS-1:0] bc_slot_vals
);
   import lgf_pkg::*;

   // Control registers.
   logic [7:0] input_en_ff;
   logic [7:0] pulldown_ff;
   lgf_pin_cfg_t [N_PINS-1:0] pin_cfg_ff;
   logic port_sel_ff;
   logic [1:0] bc_rate_ff;
   logic [N_PORTS-1:0][N_SLOTS-1:0][3:0] slot_src_ff;
   logic [7:0] rdata_ff;

   // Datapath state.
   logic [N_PORTS-1:0][2:0] fc_cnt_ff;
   logic [N_PORTS-1:0][FWD_PINS-1:0] fwd_vals_ff;
   logic [N_PINS-1:0] pin_out_ff;
   logic [N_PINS-1:0] pin_oe_n_ff;
   logic [N_PORTS-1:0][N_SLOTS-1:0] bc_vals_ff;
   logic bc_stb_ff;

   logic [N_PINS:0] synced;
   logic [N_PINS-1:0] pin_level;
   logic fsync_ext_level;
   logic bc_tick;
   logic lock_or;
   logic lock_and;
   logic [N_PINS-1:0] nxt_pin_out;

   // Pin output control registers occupy consecutive offsets from the base.
   function automatic logic is_pin_cfg_addr(input logic [7:0] addr);
      return (addr >= ADDR_PIN_OUT_BASE) && (addr < ADDR_PIN_OUT_BASE + 8'(N_PINS));
   endfunction

   function automatic logic [2:0] fc_period(input logic [2:0] link_cnt);
      if (link_cnt <= 3'h1)
         return FC_PERIOD_ONE;
      else if (link_cnt == 3'h2)
         return FC_PERIOD_TWO;
      else
         return FC_PERIOD_MANY;
   endfunction

   function automatic logic slot_value(input logic [3:0] src, input logic [N_PINS-1:0] lvl,
                                       input logic fs_int, input logic fs_ext);
      if (src < 4'(N_PINS))
         return lvl[src[2:0]];
      else if (src == SLOT_FSYNC_INT)
         return fs_int;
      else if (src == SLOT_FSYNC_EXT)
         return fs_ext;
      else
         return 1'b0;
   endfunction

   lgf_pin_sync #(
      .W(N_PINS + 1)
   ) u_sync (
      .clk(clk),
      .arst_n(arst_n),
      .async_in({frame_sync_ext, pin_in}),
      .level(synced)
   );

   // Disabled input paths read as low.
   assign pin_level = synced[N_PINS-1:0] & input_en_ff[N_PINS-1:0];
   assign fsync_ext_level = synced[N_PINS];

   lgf_bc_frame_timer u_bc_timer (
      .clk(clk),
      .arst_n(arst_n),
      .rate(bc_rate_ff),
      .frame_stb(bc_tick)
   );

   // Input and pulldown enables default on.
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         input_en_ff <= INPUT_EN_RST;
         pulldown_ff <= PULLDOWN_RST;
      end
      else if (reg_wr_en)
      begin
         if (reg_addr == ADDR_INPUT_EN)
            input_en_ff <= reg_wdata & INPUT_EN_RST;
         else if (reg_addr == ADDR_PULLDOWN)
            pulldown_ff <= reg_wdata & PULLDOWN_RST;
      end
   end

   // Per-pin output mode and source selection.
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         pin_cfg_ff <= {N_PINS{PIN_OUT_RST}};
      else if (reg_wr_en && is_pin_cfg_addr(reg_addr))
         pin_cfg_ff[3'(reg_addr - ADDR_PIN_OUT_BASE)] <= reg_wdata;
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         port_sel_ff <= 1'b0;
         bc_rate_ff <= BC_RATE_RST;
      end
      else if (reg_wr_en)
      begin
         if (reg_addr == ADDR_PORT_SEL)
            port_sel_ff <= reg_wdata[0];
         else if (reg_addr == ADDR_BC_RATE)
            bc_rate_ff <= reg_wdata[1:0];
      end
   end

   // Slot assignment of the selected port, two slots per register.
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         slot_src_ff <= {(N_PORTS * N_SLOTS){BC_SLOT_RST}};
      else if (reg_wr_en)
      begin
         if (reg_addr == ADDR_BC_SLOT0)
         begin
            slot_src_ff[port_sel_ff][0] <= reg_wdata[SLOT_LO_LSB +: 4];
            slot_src_ff[port_sel_ff][1] <= reg_wdata[SLOT_HI_LSB +: 4];
         end
         else if (reg_addr == ADDR_BC_SLOT1)
         begin
            slot_src_ff[port_sel_ff][2] <= reg_wdata[SLOT_LO_LSB +: 4];
            slot_src_ff[port_sel_ff][3] <= reg_wdata[SLOT_HI_LSB +: 4];
         end
      end
   end

   // Read data is registered; unmapped offsets read as zero.
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         rdata_ff <= 8'h00;
      else if (reg_rd_en)
      begin
         if (reg_addr == ADDR_PIN_LEVEL)
            rdata_ff <= 8'(pin_level);
         else if (reg_addr == ADDR_INPUT_EN)
            rdata_ff <= input_en_ff;
         else if (is_pin_cfg_addr(reg_addr))
            rdata_ff <= pin_cfg_ff[3'(reg_addr - ADDR_PIN_OUT_BASE)];
         else if (reg_addr == ADDR_PORT_SEL)
            rdata_ff <= {7'h00, port_sel_ff};
         else if (reg_addr == ADDR_BC_RATE)
            rdata_ff <= {6'h00, bc_rate_ff};
         else if (reg_addr == ADDR_BC_SLOT0)
            rdata_ff <= {slot_src_ff[port_sel_ff][1], slot_src_ff[port_sel_ff][0]};
         else if (reg_addr == ADDR_BC_SLOT1)
            rdata_ff <= {slot_src_ff[port_sel_ff][3], slot_src_ff[port_sel_ff][2]};
         else if (reg_addr == ADDR_PULLDOWN)
            rdata_ff <= pulldown_ff;
         else
            rdata_ff <= 8'h00;
      end
   end

   // Forward frames: each port keeps its own frame count so that spread
   // samples are taken only when the whole group has arrived.
   for (genvar p = 0; p < N_PORTS; p++)
   begin : g_fwd
      always_ff @(posedge clk or negedge arst_n)
      begin
         if (!arst_n)
         begin
            fc_cnt_ff[p] <= 3'h0;
            fwd_vals_ff[p] <= '0;
         end
         else if (fwd_frame[p].stb)
         begin
            if (fc_cnt_ff[p] >= fc_period(fwd_frame[p].link_cnt) - 3'h1)
            begin
               fc_cnt_ff[p] <= 3'h0;
               fwd_vals_ff[p] <= fwd_frame[p].vals;
            end
            else
               fc_cnt_ff[p] <= fc_cnt_ff[p] + 3'h1;
         end
      end
   end

   assign lock_or = |(rx_lock & rx_port_en);
   assign lock_and = (|rx_port_en) && ((rx_lock & rx_port_en) == rx_port_en);

   // Any port value to any pin.
   always_comb
   begin
      for (int i = 0; i < N_PINS; i++)
      begin
         nxt_pin_out[i] = 1'b0;
         if (pin_cfg_ff[i].grp == GRP_PORT0 || pin_cfg_ff[i].grp == GRP_PORT1)
         begin
            if (pin_cfg_ff[i].sel == SEL_PORT_LOCK)
               nxt_pin_out[i] = rx_lock[pin_cfg_ff[i].grp[0]];
            else if (pin_cfg_ff[i].sel < 3'(FWD_PINS))
               nxt_pin_out[i] = fwd_vals_ff[pin_cfg_ff[i].grp[0]][pin_cfg_ff[i].sel[1:0]];
         end
         else if (pin_cfg_ff[i].grp == GRP_STATUS)
         begin
            if (pin_cfg_ff[i].sel == SEL_STAT_VALUE)
               nxt_pin_out[i] = pin_cfg_ff[i].val;
            else if (pin_cfg_ff[i].sel == SEL_STAT_LOCK_OR)
               nxt_pin_out[i] = lock_or;
            else if (pin_cfg_ff[i].sel == SEL_STAT_LOCK_AND)
               nxt_pin_out[i] = lock_and;
            else if (pin_cfg_ff[i].sel == SEL_STAT_FSYNC)
               nxt_pin_out[i] = frame_sync_int;
         end
      end
   end

   // Pin drive, one register stage keeps latency flat.
   // Jitter follows the update cadence; values hold between updates.
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pin_out_ff <= '0;
         pin_oe_n_ff <= '1;
      end
      else
      begin
         pin_out_ff <= nxt_pin_out;
         for (int i = 0; i < N_PINS; i++)
            pin_oe_n_ff[i] <= ~pin_cfg_ff[i].oe;
      end
   end

   // Sample every slot once per back-channel frame.
   // Four slots per port, any pin, shared pins, frame sync.
   for (genvar p = 0; p < N_PORTS; p++)
   begin : g_bc_port
      for (genvar s = 0; s < N_SLOTS; s++)
      begin : g_bc_slot
         always_ff @(posedge clk or negedge arst_n)
         begin
            if (!arst_n)
               bc_vals_ff[p][s] <= 1'b0;
            else if (bc_tick)
               bc_vals_ff[p][s] <= slot_value(slot_src_ff[p][s], pin_level,
                                              frame_sync_int, fsync_ext_level);
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         bc_stb_ff <= 1'b0;
      else
         bc_stb_ff <= bc_tick;
   end

   assign reg_rdata = rdata_ff;
   assign pin_out = pin_out_ff;
   assign pin_oe_n = pin_oe_n_ff;
   assign pin_in_en = input_en_ff[N_PINS-1:0];
   assign pin_pd_en = pulldown_ff[N_PINS-1:0];
   assign bc_frame_stb = bc_stb_ff;
   assign bc_slot_vals = bc_vals_ff;
endmodule
`default_nettype wire

/* verif/lgf_serializer_model.sv */
// Purpose: Remote serializer model sending forward frames on both receive ports.
// Assumes: The gap input sets the cycles from one frame to the next.
// Notes: Value lines carry inverted data outside the strobe so stale sampling shows.
`timescale 1ns/10ps
`default_nettype none
module lgf_serializer_model (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [3:0] gap,
   input wire logic [2:0] link_cnt,
   input wire logic [1:0][3:0] vals,
   output lgf_pkg::lgf_fwd_frame_t [1:0] fwd_frame
);
   import lgf_pkg::*;
   logic [3:0] cnt_ff;
   logic stb_ff;
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cnt_ff <= 4'h0;
         stb_ff <= 1'b0;
      end
      else
      begin
         stb_ff <= (cnt_ff >= gap - 4'h1);
         cnt_ff <= (cnt_ff >= gap - 4'h1) ? 4'h0 : cnt_ff + 4'h1;
      end
   end
   always_comb
   begin
      for (int p = 0; p < 2; p++)
      begin
         fwd_frame[p].stb = stb_ff;
         fwd_frame[p].link_cnt = link_cnt;
         fwd_frame[p].vals = stb_ff ? vals[p] : ~vals[p];
      end
   end
endmodule
`default_nettype wire

/* verif/lgf_gpio_fwd_checker.sv */
// Purpose: Port-level assertions for the link pin forwarding block.
// Assumes: One clock domain; reset is asynchronous and active low.
// Notes: The frame period check disarms once the rate register is written.
`timescale 1ns/10ps
`default_nettype none
module lgf_gpio_fwd_checker #(
   parameter int N_PINS = 7,
   parameter int N_PORTS = 2,
   parameter int N_SLOTS = 4
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic [N_PINS-1:0] pin_oe_n,
   input wire logic [N_PINS-1:0] pin_in_en,
   input wire logic [N_PINS-1:0] pin_pd_en,
   input wire logic bc_frame_stb,
   input wire logic [N_PORTS-1:0][N_SLOTS-1:0] bc_slot_vals
);
   import lgf_pkg::*;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);
   logic rate_fixed_ff;
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         rate_fixed_ff <= 1'b1;
      else if (reg_wr_en && reg_addr == ADDR_BC_RATE)
         rate_fixed_ff <= 1'b0;
   end
   a_reset_state: assert property (
      $rose(arst_n) |-> &pin_oe_n && &pin_in_en && &pin_pd_en)
      else $error("pins not inputs with enables set after reset");
   a_stb_single: assert property (
      bc_frame_stb |=> !bc_frame_stb [*8])
      else $error("frame strobe too long or frames too close");
   a_frame_period: assert property (
      bc_frame_stb && rate_fixed_ff |-> ##60 (bc_frame_stb || !rate_fixed_ff))
      else $error("back-channel frame is not 60 cycles");
   a_slot_hold: assert property (
      !bc_frame_stb |-> $stable(bc_slot_vals))
      else $error("slot values changed inside a frame");
   a_inen_write: assert property (
      reg_wr_en && reg_addr == ADDR_INPUT_EN |=> pin_in_en == $past(reg_wdata[N_PINS-1:0]))
      else $error("input enables do not follow write");
   a_pd_write: assert property (
      reg_wr_en && reg_addr == ADDR_PULLDOWN |=> pin_pd_en == $past(reg_wdata[N_PINS-1:0]))
      else $error("pulldown enables do not follow write");
   a_inen_read: assert property (
      reg_rd_en && !reg_wr_en && reg_addr == ADDR_INPUT_EN
      |=> reg_rdata == {1'b0, $past(pin_in_en)})
      else $error("input enable readback wrong");
   a_unmapped_read: assert property (
      reg_rd_en && reg_addr inside {[8'h22:8'h6d]} |=> reg_rdata == 8'h00)
      else $error("unmapped offset read not zero");
   a_rdata_hold: assert property (
      !reg_rd_en |=> $stable(reg_rdata))
      else $error("read data changed without a read");
endmodule
bind lgf_gpio_fwd lgf_gpio_fwd_checker #(
   .N_PINS(N_PINS), .N_PORTS(N_PORTS), .N_SLOTS(N_SLOTS)
) u_checker (
   .clk, .arst_n, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata,
   .pin_oe_n, .pin_in_en, .pin_pd_en, .bc_frame_stb, .bc_slot_vals
);
`default_nettype wire

/* verif/lgf_gpio_fwd_bench.sv */
// Purpose: Self-checking bench for the link pin forwarding block.
// Assumes: The serializer model supplies forward frames; pads resolve from enables.
// Notes: Frame counting needs a model gap of at least two cycles.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module lgf_gpio_fwd_bench;
   import lgf_pkg::*;
   logic clk, arst_n, reg_wr_en, reg_rd_en, fs_int, fs_ext, bc_stb;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic [1:0] rx_port_en, rx_lock;
   logic [6:0] pin_in, pin_out, pin_oe_n, pin_in_en, pin_pd_en, ext_pin;
   logic [1:0][3:0] bc_vals, vals;
   logic [3:0] gap;
   logic [2:0] link_cnt;
   lgf_fwd_frame_t [1:0] fwd_frame;
   int miscompares, n_checks, n;
   assign pin_in = (pin_out & ~pin_oe_n) | (ext_pin & pin_oe_n);
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   lgf_serializer_model ser (.clk, .arst_n, .gap, .link_cnt, .vals, .fwd_frame);
   lgf_gpio_fwd dut (.clk, .arst_n, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata,
      .reg_rdata, .fwd_frame, .rx_port_en, .rx_lock, .frame_sync_int(fs_int),
      .frame_sync_ext(fs_ext), .pin_in, .pin_out, .pin_oe_n, .pin_in_en, .pin_pd_en,
      .bc_frame_stb(bc_stb), .bc_slot_vals(bc_vals));
   task automatic end_of_test();
      $display("checks=%0d miscompares=%0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic hang();
      miscompares++;
      end_of_test();
   endtask
   task automatic tick(input int c);
      repeat (c) @(posedge clk);
      #1;
   endtask
   // A spare cycle after each access keeps strobes from being reassigned in one step.
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      reg_wr_en = 1'b1;
      reg_addr = a;
      reg_wdata = v;
      tick(1);
      reg_wr_en = 1'b0;
      tick(1);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
      reg_rd_en = 1'b1;
      reg_addr = a;
      tick(1);
      reg_rd_en = 1'b0;
      tick(1);
      `CHK(reg_rdata, e)
   endtask
   task automatic wait_pins(input logic [6:0] e, output int c);
      c = 0;
      for (int i = 0; i < 200; i++)
      begin
         if (fwd_frame[0].stb === 1'b1)
            c++;
         tick(1);
         if (pin_out === e)
            return;
      end
      hang();
   endtask
   task automatic wait_frame(output int c);
      for (c = 1; c < 1300; c++)
      begin
         tick(1);
         if (bc_stb === 1'b1)
            return;
      end
      hang();
   endtask
   task automatic t_regs();
      `CHK(pin_oe_n, 7'h7f)
      `CHK(pin_in_en & pin_pd_en, 7'h7f)
      rdchk(ADDR_PULLDOWN, 8'h7f);
      rdchk(ADDR_BC_SLOT1, 8'h00);
      wr(ADDR_INPUT_EN, 8'hd5);
      `CHK(pin_in_en, 7'h55)
      rdchk(ADDR_INPUT_EN, 8'h55);
      wr(ADDR_PULLDOWN, 8'h2a);
      `CHK(pin_pd_en, 7'h2a)
      wr(8'h30, 8'hff);
      rdchk(8'h30, 8'h00);
      wr(ADDR_INPUT_EN, 8'h7f);
   endtask
   task automatic t_route();
      for (int i = 0; i < 7; i++)
         wr(ADDR_PIN_OUT_BASE + 8'(i), {(i < 4 ? GRP_PORT0 : GRP_PORT1), 3'(i % 4), 2'b01});
      vals = {4'h6, 4'h9};
      wait_pins({3'b110, 4'h9}, n);
      `CHK(pin_oe_n, 7'h00)
   endtask
   task automatic t_rate();
      logic [3:0] a;
      for (int k = 0; k < 4; k++)
      begin
         link_cnt = 3'(k + 1);
         gap = (k == 3) ? 4'h9 : 4'h4;
         a = ~pin_out[3:0];
         vals[0] = a;
         wait_pins({pin_out[6:4], a}, n);
         vals[0] = ~a;
         wait_pins({pin_out[6:4], ~a}, n);
         `CHK(n, (k == 0) ? 1 : (k == 1) ? 2 : 5)
      end
   endtask
   task automatic t_status();
      rx_port_en = 2'b01;
      rx_lock = 2'b10;
      wr(ADDR_PIN_OUT_BASE, {GRP_STATUS, SEL_STAT_VALUE, 2'b11});
      tick(2);
      `CHK(pin_out[0], 1'b1)
      wr(ADDR_PIN_OUT_BASE, {GRP_STATUS, SEL_STAT_LOCK_OR, 2'b01});
      tick(2);
      `CHK(pin_out[0], 1'b0)
      rx_lock = 2'b11;
      tick(3);
      `CHK(pin_out[0], 1'b1)
      wr(ADDR_PIN_OUT_BASE + 8'h01, {GRP_STATUS, SEL_STAT_LOCK_AND, 2'b01});
      wr(ADDR_PIN_OUT_BASE + 8'h02, {GRP_PORT1, SEL_PORT_LOCK, 2'b01});
      tick(2);
      `CHK(pin_out[2:1], 2'b11)
      rx_port_en = 2'b11;
      rx_lock = 2'b01;
      tick(3);
      `CHK(pin_out[2:0], 3'b001)
      fs_int = 1'b1;
      wr(ADDR_PIN_OUT_BASE + 8'h06, {GRP_STATUS, SEL_STAT_FSYNC, 2'b01});
      tick(2);
      `CHK(pin_out[6], 1'b1)
   endtask
   task automatic t_backchan();
      for (int i = 0; i < 7; i++)
         wr(ADDR_PIN_OUT_BASE + 8'(i), 8'h00);
      // Pad levels hold for many frames.
      ext_pin = 7'h48;
      wr(ADDR_PORT_SEL, 8'h00);
      wr(ADDR_BC_SLOT0, 8'h33);
      wr(ADDR_BC_SLOT1, {SLOT_FSYNC_EXT, SLOT_FSYNC_INT});
      wr(ADDR_PORT_SEL, 8'h01);
      wr(ADDR_BC_SLOT0, 8'h06);
      rdchk(ADDR_BC_SLOT0, 8'h06);
      wait_frame(n);
      wait_frame(n);
      `CHK(n, 60)
      `CHK(bc_vals, 8'h17)
      rdchk(ADDR_PIN_LEVEL, 8'h48);
      fs_ext = 1'b1;
      wr(ADDR_INPUT_EN, 8'h77);
      wait_frame(n);
      wait_frame(n);
      `CHK(bc_vals, 8'h1c)
      // A rate change restarts the frame, so the third strobe gives a clean period.
      wr(ADDR_BC_RATE, {6'h00, BC_RATE_10M});
      repeat (3) wait_frame(n);
      `CHK(n, 300)
      wr(ADDR_BC_RATE, {6'h00, BC_RATE_2M5});
      repeat (3) wait_frame(n);
      `CHK(n, 1200)
   endtask
   initial
   begin
      arst_n = 1'b0;
      {reg_wr_en, reg_rd_en, fs_int, fs_ext} = 4'h0;
      {reg_addr, reg_wdata} = 16'h0000;
      {rx_port_en, rx_lock} = 4'hc;
      {ext_pin, vals} = 15'h0000;
      gap = 4'h4;
      link_cnt = 3'h1;
      tick(3);
      arst_n = 1'b1;
      t_regs();
      t_route();
      t_rate();
      t_status();
      t_backchan();
      end_of_test();
   end
endmodule
`default_nettype wire
